// File: rtl/vcs_defs.vh
/*
 * constants for the vco calibration sequencer: register offsets, field
 * positions, reset values and timing counts.
 * assumes inclusion by bare name from the sequencer module.
 */
// Contract
// - calibration controller runs from divided reference clock
// - first start: set start bit, then update
// - later starts need zero, update, one, update
// - readable finished bit reads one when done
// - calibration start asserts internal output sync hold
// - finish releases sync hold, then closes loop; the code does both on the same edge
// - calibration clock is phase detector over divider
// - run lasts 4400 calibration clock cycles
// - no automatic start on pll divider changes
// - nonvolatile auto-load runs calibration without host
// - feedback mode 01b selects internal zero delay
// - external mode picks channel divider by select field
// - programmable r-path and n-path delays provided
// - feedback mode 11b selects external zero delay
`ifndef VCS_DEFS_VH
`define VCS_DEFS_VH

// register word indices, byte address is four times the index
`define VCS_PLL_CTRL_IDX    10'h018
`define VCS_FB_CTRL_IDX     10'h01e
`define VCS_STATUS_IDX      10'h01f
`define VCS_R_DIV_IDX       10'h011
`define VCS_DELAY_IDX       10'h019
`define VCS_VCO_DIV_IDX     10'h1e0
`define VCS_UPDATE_IDX      10'h232

// field positions
`define VCS_CAL_START_BIT   0
`define VCS_CAL_DIV_LSB     1
`define VCS_FB_MODE_LSB     1
`define VCS_FB_SEL_LSB      3
`define VCS_CAL_DONE_BIT    6
`define VCS_UPDATE_BIT      0

// feedback modes
`define VCS_FB_INTERNAL     2'h1
`define VCS_FB_EXTERNAL     2'h3

// reset values
`define VCS_PLL_CTRL_RST    8'h00
`define VCS_FB_CTRL_RST     8'h00
`define VCS_R_DIV_RST       14'h0001
`define VCS_DELAY_RST       8'h00
`define VCS_VCO_DIV_RST     3'h0

// calibration length in calibration clock cycles
`define VCS_CAL_CYCLES      13'd4400

`endif

// File: rtl/vcs_sequencer.v
/*
 * vco calibration sequencer with an ahb-lite register slave, the
 * reference-derived calibration clock enable, the output sync hold and the
 * zero-delay feedback selection.
 *
 * register set, one aligned 32-bit word each, data in the low bits:
 *   pll control    start bit in bit 0, calibration divider code in [2:1]
 *   feedback ctrl  feedback mode in [2:1], feedback divider select in [4:3]
 *   status         calibration finished flag in bit 6, read only
 *   r divider      reference divide count, a written zero becomes one
 *   path delays    r-path delay in [7:0], n-path delay in [15:8]
 *   vco divider    three-bit divider setting, stored and read back only, drives no output
 *   update         writing bit 0 as one applies all staged values except the vco divider
 *
 * staging:
 *   every write lands in a staged copy first. the update strobe copies the
 *   staged copies into the applied set one cycle after its data phase, and
 *   the sequencer looks at the applied set one cycle later again. so a run
 *   starts two cycles after the data phase of the update write.
 *
 * starting a run:
 *   the first applied start bit of one after reset starts a run. after
 *   that only an applied zero followed by an applied one starts one, so a
 *   host that leaves the bit high and updates again gets no new run.
 *   the first auto-load indication after reset starts one run by itself.
 *   divider changes never start a run on their own.
 *
 * during a run:
 *   the sync hold output is high, the loop-closed output is low and the
 *   finished flag reads zero. the reference ticks are divided by the
 *   applied r count to the phase detector rate, and that again by the
 *   calibration ratio 2, 4, 8 or 16 to the calibration clock.
 *   a run lasts CAL_CYCLES calibration clocks, so the hold lasts
 *   CAL_CYCLES times r times the ratio reference ticks.
 *
 * end of a run:
 *   the hold drops, the loop-closed output rises and the finished flag
 *   sets, all on the same edge. the flag stays set until the next start.
 *
 * hazards:
 *   the dividers only count inside a run and restart at zero for every
 *   run, so a run length never depends on earlier history.
 *   changing r or the calibration code during a run changes its length;
 *   the host is expected to wait for the finished flag first.
 *   the slave has no wait states and always answers okay.
 *
 * assumes ref_tick marks one reference input clock period in hclk and that
 * a single ahb-lite master drives the bus, single word transfers only.
 * assumes inputs synchronous to hclk and hresetn released away from an edge.
 */
`timescale 1ns/1ps
`include "vcs_defs.vh"

module vcs_sequencer #(
	parameter CAL_CYCLES = 4400,
	parameter RW         = 14
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        ref_tick,
	input  wire        autoload_done,
	output reg         sync_hold,
	output reg         loop_closed,
	output reg  [1:0]  fb_mode,
	output reg  [1:0]  fb_src_sel,
	output reg         fb_internal,
	output reg         fb_external,
	output reg  [7:0]  r_path_delay,
	output reg  [7:0]  n_path_delay,
	output reg  [RW-1:0] r_divider
);

	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_DONE = 2'h2;

	// calibration divide ratio from code
	function [4:0] cal_ratio;
		input [1:0] code;
		begin
			cal_ratio = 5'd2 << code;
		end
	endfunction

	// register word index from a byte address
	function [9:0] word_idx;
		input [11:0] byte_addr;
		begin
			word_idx = byte_addr[11:2];
		end
	endfunction

	// address phase capture
	reg        wr_pend_q;
	reg [11:0] addr_q;
	reg [7:0]  pll_ctrl_q;     // staged values
	reg [7:0]  fb_ctrl_q;
	reg [RW-1:0] r_div_q;
	reg [15:0] delay_q;
	reg [2:0]  vco_div_q;
	reg [7:0]  pll_act_q;      // applied values
	reg        start_prev_q;
	reg        first_q;
	reg [1:0]  state_q;
	reg        done_q;
	reg [RW-1:0] r_cnt_q;
	reg [4:0]  div_cnt_q;
	reg [12:0] cal_cnt_q;
	reg        auto_seen_q;
	reg        update_q;
	reg [1:0]  state_d;        // next values of the sequence
	reg        done_d;
	reg        hold_d;
	reg        loop_d;
	reg [12:0] cal_cnt_d;
	reg        first_d;
	reg        auto_seen_d;
	reg        start_prev_d;
	reg [31:0] rd_word;        // read mux output

	wire        take       = hsel & hready & htrans[1];
	wire        wr_data    = wr_pend_q;
	wire [9:0]  widx       = word_idx(addr_q);
	wire        upd_req    = wr_data && widx == `VCS_UPDATE_IDX && hwdata[`VCS_UPDATE_BIT];
	wire        pfd_tick   = ref_tick && r_cnt_q == r_divider - 1'b1;
	wire        cal_tick   = pfd_tick && div_cnt_q == cal_ratio(pll_act_q[2:1]) - 5'd1;
	wire        last_cal   = {19'd0, cal_cnt_q} == CAL_CYCLES - 1;
	wire        man_start  = update_q && pll_act_q[`VCS_CAL_START_BIT] && (first_q || !start_prev_q);
	wire        auto_start = autoload_done && !auto_seen_q;
	wire        start_req  = man_start || auto_start;

	// read data mux over the readable registers
	always @* begin
		rd_word = 32'h00000000;
		case (word_idx(haddr))
		`VCS_PLL_CTRL_IDX: rd_word = {24'h000000, pll_ctrl_q};
		`VCS_FB_CTRL_IDX:  rd_word = {24'h000000, fb_ctrl_q};
		`VCS_STATUS_IDX:   rd_word = {24'h000000, 1'b0, done_q, 6'h00};
		`VCS_R_DIV_IDX:    rd_word = {{(32-RW){1'b0}}, r_div_q};
		`VCS_DELAY_IDX:    rd_word = {16'h0000, delay_q};
		`VCS_VCO_DIV_IDX:  rd_word = {29'h00000000, vco_div_q};
		default:           rd_word = 32'h00000000;
		endcase
	end

	// bus phase tracking, zero wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= 12'h000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			wr_pend_q <= take & hwrite;
			if (take)
				addr_q <= haddr;
			hrdata <= 32'h00000000;
			if (take && !hwrite)
				hrdata <= rd_word;
		end
	end

	// staged register writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_ctrl_q <= `VCS_PLL_CTRL_RST;
			fb_ctrl_q  <= `VCS_FB_CTRL_RST;
			r_div_q    <= `VCS_R_DIV_RST;
			delay_q    <= {`VCS_DELAY_RST, `VCS_DELAY_RST};
			vco_div_q  <= `VCS_VCO_DIV_RST;
		end else if (wr_data) begin
			case (widx)
			`VCS_PLL_CTRL_IDX: pll_ctrl_q <= hwdata[7:0];
			`VCS_FB_CTRL_IDX:  fb_ctrl_q  <= hwdata[7:0];
			`VCS_R_DIV_IDX:    r_div_q    <= (hwdata[RW-1:0] == {RW{1'b0}}) ? `VCS_R_DIV_RST : hwdata[RW-1:0];
			`VCS_DELAY_IDX:    delay_q    <= hwdata[15:0];
			`VCS_VCO_DIV_IDX:  vco_div_q  <= hwdata[2:0];
			default:           pll_ctrl_q <= pll_ctrl_q;
			endcase
		end
	end

	// update strobe applies staged values to the active set
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			update_q     <= 1'b0;
			pll_act_q    <= `VCS_PLL_CTRL_RST;
			fb_mode      <= 2'h0;
			fb_src_sel   <= 2'h0;
			fb_internal  <= 1'b0;
			fb_external  <= 1'b0;
			r_path_delay <= 8'h00;
			n_path_delay <= 8'h00;
			r_divider    <= `VCS_R_DIV_RST;
		end else begin
			update_q <= upd_req;
			if (upd_req) begin
				pll_act_q    <= pll_ctrl_q;
				fb_mode      <= fb_ctrl_q[2:1];
				fb_src_sel   <= fb_ctrl_q[4:3];
				fb_internal  <= fb_ctrl_q[2:1] == `VCS_FB_INTERNAL;
				fb_external  <= fb_ctrl_q[2:1] == `VCS_FB_EXTERNAL;
				r_path_delay <= delay_q[7:0];
				n_path_delay <= delay_q[15:8];
				r_divider    <= r_div_q;
			end
		end
	end

	// reference divide down to the phase detector rate
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_cnt_q <= {RW{1'b0}};
		end else if (state_q != ST_RUN) begin
			r_cnt_q <= {RW{1'b0}};
		end else if (ref_tick) begin
			r_cnt_q <= pfd_tick ? {RW{1'b0}} : r_cnt_q + 1'b1;
		end
	end

	// phase detector rate divided by the calibration ratio
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= 5'd0;
		end else if (state_q != ST_RUN) begin
			div_cnt_q <= 5'd0;
		end else if (pfd_tick) begin
			div_cnt_q <= cal_tick ? 5'd0 : div_cnt_q + 5'd1;
		end
	end

	// next-state decode of the calibration sequence
	always @* begin
		state_d      = state_q;
		done_d       = done_q;
		hold_d       = sync_hold;
		loop_d       = loop_closed;
		cal_cnt_d    = cal_cnt_q;
		first_d      = first_q;
		auto_seen_d  = auto_seen_q;
		start_prev_d = update_q ? pll_act_q[`VCS_CAL_START_BIT] : start_prev_q;
		case (state_q)
		ST_IDLE, ST_DONE: begin
			// only explicit requests or the one auto-load start a run
			if (start_req) begin
				state_d     = ST_RUN;
				done_d      = 1'b0;
				hold_d      = 1'b1;
				loop_d      = 1'b0;
				cal_cnt_d   = 13'd0;
				first_d     = 1'b0;
				auto_seen_d = auto_seen_q | autoload_done;
			end
		end
		ST_RUN: begin
			if (cal_tick && last_cal) begin
				state_d = ST_DONE;
				hold_d  = 1'b0;
				loop_d  = 1'b1;
				done_d  = 1'b1;
			end else if (cal_tick) begin
				cal_cnt_d = cal_cnt_q + 13'd1;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	// calibration sequence registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q      <= ST_IDLE;
			done_q       <= 1'b0;
			sync_hold    <= 1'b0;
			loop_closed  <= 1'b0;
			cal_cnt_q    <= 13'd0;
			start_prev_q <= 1'b0;
			first_q      <= 1'b1;
			auto_seen_q  <= 1'b0;
		end else begin
			state_q      <= state_d;
			done_q       <= done_d;
			sync_hold    <= hold_d;
			loop_closed  <= loop_d;
			cal_cnt_q    <= cal_cnt_d;
			start_prev_q <= start_prev_d;
			first_q      <= first_d;
			auto_seen_q  <= auto_seen_d;
		end
	end

endmodule

// File: verif/vcs_properties.sv
/* vcs checker: port properties of the sequencer.
 * assumes a bind onto vcs_sequencer. */
`timescale 1ns/1ps
module vcs_checker #(
	parameter CAL_CYCLES = 4400
) (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [11:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        ref_tick,
	input wire        sync_hold,
	input wire        loop_closed,
	input wire [1:0]  fb_mode,
	input wire        fb_internal,
	input wire        fb_external
);
	int  ticks_q;
	wire rd_stat = hsel && hready && htrans[1] && !hwrite && haddr == 12'h07c;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// reference ticks seen while held
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn || !sync_hold)
			ticks_q <= 0;
		else if (ref_tick)
			ticks_q <= ticks_q + 1;
	end
	hold_opens_loop_a: assert property (sync_hold |-> !loop_closed) else $error("loop closed under hold");
	release_closes_a: assert property ($fell(sync_hold) |-> loop_closed) else $error("loop open after run");
	release_on_tick_a: assert property ($fell(sync_hold) |-> $past(ref_tick) || $past(ref_tick, 2))
		else $error("run ended off a tick");
	run_length_a: assert property ($fell(sync_hold) |-> ticks_q + 1 >= 2 * CAL_CYCLES)
		else $error("run too short");
	fb_internal_a: assert property (fb_internal == (fb_mode == 2'h1)) else $error("internal mode wrong");
	fb_external_a: assert property (fb_external == (fb_mode == 2'h3)) else $error("external mode wrong");
	busy_status_a: assert property (rd_stat && sync_hold ##1 sync_hold |-> !hrdata[6])
		else $error("done set during run");
	done_status_a: assert property (rd_stat && loop_closed ##1 loop_closed |-> hrdata[6])
		else $error("done clear after run");
	cover property ($rose(sync_hold));
	cover property ($fell(sync_hold));
	cover property (fb_external);
endmodule
bind vcs_sequencer vcs_checker #(.CAL_CYCLES(CAL_CYCLES)) chk (.*);

// File: verif/vcs_ref_src.sv
/* vcs reference source: periodic reference ticks.
 * assumes a free running hclk. */
`timescale 1ns/1ps
module vcs_ref_src #(
	parameter PERIOD = 3
) (
	input wire hclk,
	input wire hresetn,
	output reg ref_tick
);
	int cnt_q;
	// stable reference, one tick every PERIOD clocks
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_q <= 0;
		else
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
		ref_tick <= hresetn && cnt_q == PERIOD - 1;
	end
endmodule

// File: verif/vco_calibration_sequencer_tb_top.sv
/* vcs bench: register access sequences with expected values.
 * assumes the sequencer slave answers with hreadyout. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module vco_calibration_sequencer_tb_top;
	localparam CAL = 4;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, autoload_done = 0;
	logic [11:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, rv;
	wire [31:0] hrdata;
	wire hreadyout, hresp, ref_tick, sync_hold, loop_closed, fb_internal, fb_external;
	wire [1:0] fb_mode, fb_src_sel;
	wire [7:0] r_path_delay, n_path_delay;
	wire [13:0] r_divider;
	int n_errors = 0, num_checks = 0, ticks;
	always #2 hclk = ~hclk;
	always @(posedge hclk) if (sync_hold && ref_tick) ticks++;
	vcs_ref_src #(.PERIOD(3)) src (.hclk(hclk), .hresetn(hresetn), .ref_tick(ref_tick));
	vcs_sequencer #(.CAL_CYCLES(CAL)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_tick(ref_tick),
		.autoload_done(autoload_done), .sync_hold(sync_hold), .loop_closed(loop_closed),
		.fb_mode(fb_mode), .fb_src_sel(fb_src_sel), .fb_internal(fb_internal), .fb_external(fb_external),
		.r_path_delay(r_path_delay), .n_path_delay(n_path_delay), .r_divider(r_divider));
	// one single-word transfer
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hreadyout);
		rv = hrdata;
	endtask
	task upd;
		xfer(1, 12'h8c8, 32'h1);
		repeat (20) @(posedge hclk);
	endtask
	// one run: status during it, tick count, status after it
	task meas(input int exp);
		int k;
		k = 0;
		while (!sync_hold && k < 40) begin
			@(posedge hclk);
			k++;
		end
		xfer(0, 12'h07c, 0);
		`CHK(rv[6], 1'b0)
		while (sync_hold && k < 3000) begin
			@(posedge hclk);
			k++;
		end
		`CHK(ticks >= exp - 1 && ticks <= exp + 1, 1'b1)
		xfer(0, 12'h07c, 0);
		`CHK(rv[6], 1'b1)
		`CHK(loop_closed, 1'b1)
		ticks = 0;
	endtask
	task print_verdict;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(r_divider, 14'h0001)
		autoload_done <= 1'b1;
		meas(CAL * 2);
		xfer(1, 12'h780, 32'h1);
		xfer(1, 12'h044, 32'h2);
		xfer(1, 12'h060, 32'h0);
		upd;
		`CHK(sync_hold, 1'b0)
		`CHK(r_divider, 14'h0002)
		for (int c = 0; c < 4; c++) begin
			xfer(1, 12'h060, (c << 1) | 1);
			xfer(1, 12'h060, (c << 1) | 1);
			upd;
			meas(CAL * 2 * (2 << c));
			upd;
			`CHK(sync_hold, 1'b0)
			xfer(1, 12'h060, 32'h0);
			upd;
		end
		for (int m = 0; m < 4; m++) begin
			xfer(1, 12'h078, (m << 3) | (m << 1));
			upd;
			`CHK({fb_mode, fb_src_sel}, {2'(m), 2'(m)})
			`CHK({fb_internal, fb_external}, {m == 1, m == 3})
		end
		xfer(1, 12'h064, 32'h00005a3c);
		upd;
		`CHK({n_path_delay, r_path_delay}, 16'h5a3c)
		xfer(0, 12'h3f0, 0);
		`CHK(rv, 32'h00000000)
		print_verdict;
	end
endmodule
